// >>> logic/led_indicator_select.sv
// Two programmable indicator LED drivers with a Wishbone configuration register.
//
// Notes on behaviour
// [R1]: First LED select field, bits 15:12, reset 0000.
// [R2]: Second LED select field, bits 11:8, reset 0100.
// [R3]: Codes 1-3 show stretched transmit, receive, collision.
// [R4]: Codes 0100/0101 show link and duplex continuously.
// [R5]: Code 0111 shows stretched receive-or-transmit activity.
// [R6]: Code 1000 forces on, 1001 forces off.
// [R7]: Codes 1010/1011 blink fast and slow.
// [R8]: Software avoids codes 0110 and 1111.
// [R9]: Code 1100 combines link solid with receive blinking.
// [R10]: Code 1101 blinks on activity even without link.
// [R11]: Link drives solid on; secondary event blinks.
// [R12]: Full duplex solid on; collisions blink the LED.
// [R13]: Combined modes always stretch, ignoring the enable.
// [R14]: Code 1110 selects duplex and collision combined.
// [R15]: Bit 1 enables stretching globally, resets enabled.
// [R16]: Bits 3:2 select 30, 60 or 100 ms.
// [R17]: Test blink rates come from a clock divider.
//
// Register access over Wishbone was decided locally.
`include "lis_cfg.svh"
module led_indicator_select
  import lis_pkg::*;
#(
  parameter int STRETCH_SHORT_CYC = `LIS_MS_TO_CYC(`LIS_STRETCH_SHORT_MS),
  parameter int STRETCH_MID_CYC   = `LIS_MS_TO_CYC(`LIS_STRETCH_MID_MS),
  parameter int STRETCH_LONG_CYC  = `LIS_MS_TO_CYC(`LIS_STRETCH_LONG_MS),
  parameter int FAST_HALF_CYC     = `LIS_MS_TO_CYC(`LIS_FAST_HALF_MS),
  parameter int SLOW_HALF_CYC     = `LIS_MS_TO_CYC(`LIS_SLOW_HALF_MS),
  parameter int COUNT_W           = 22
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [`LIS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  output wire logic [31:0]            wb_dat_o,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic                   wb_we_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  output wire logic                   wb_ack_o,
  input  wire logic                   speedIs100,
  input  wire logic                   txEvent,
  input  wire logic                   rxEvent,
  input  wire logic                   collisionEvent,
  input  wire logic                   linkUp,
  input  wire logic                   fullDuplex,
  output wire logic                   firstLedOn,
  output wire logic                   secondLedOn
);
  import lis_pkg::*;

  // Configuration register and bus slave.
  logic [15:0] cfgQ;
  logic [15:0] cfgD;
  logic        ackQ;
  logic [31:0] rdataQ;
  logic [31:0] rdataD;

  wire busReq    = wb_cyc_i && wb_stb_i;
  wire cfgHit    = (wb_adr_i == `LIS_CFG_OFFSET);
  wire writeFire = busReq && ackQ && wb_we_i && cfgHit;
  wire [15:0] cfgRead = {cfgQ[15:1], 1'b0};
  wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // A write lands on the same edge the master sees ack, so both agree on when it took effect.
  assign cfgD = writeFire ? ((cfgQ & ~laneMask) | (wb_dat_i[15:0] & laneMask)) : cfgQ;
  assign rdataD = (busReq && !ackQ && cfgHit) ? {16'h0000, cfgRead} : 32'h0000_0000;
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdataQ;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfgQ <= `LIS_CFG_RESET; // [R1] [R2] [R15]
    end else begin
      cfgQ <= cfgD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ackQ   <= 1'b0;
      rdataQ <= 32'h0000_0000;
    end else begin
      ackQ   <= busReq && !ackQ;
      rdataQ <= rdataD;
    end
  end

  // Field decode.
  wire       stretchEn = cfgQ[`LIS_STRETCH_EN_BIT]; // [R15]
  lis_len_t  lenSel;
  assign lenSel = cfgQ[`LIS_LEN_HI:`LIS_LEN_LO]; // [R16]
  lis_sel_e  selCode [2];
  assign selCode[0] = lis_sel_e'(cfgQ[`LIS_FIRST_SEL_HI:`LIS_FIRST_SEL_LO]);   // [R1]
  assign selCode[1] = lis_sel_e'(cfgQ[`LIS_SECOND_SEL_HI:`LIS_SECOND_SEL_LO]); // [R2]

  // Test blink divider: two half-period counters share nothing but the clock and reset.
  logic [COUNT_W-1:0] fastCntQ;
  logic [COUNT_W-1:0] slowCntQ;
  logic               fastPhaseQ;
  logic               slowPhaseQ;
  wire fastWrap = (fastCntQ == COUNT_W'(FAST_HALF_CYC - 1));
  wire slowWrap = (slowCntQ == COUNT_W'(SLOW_HALF_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fastCntQ   <= '0;
      slowCntQ   <= '0;
      fastPhaseQ <= 1'b0;
      slowPhaseQ <= 1'b0;
    end else begin
      fastCntQ   <= fastWrap ? '0 : fastCntQ + COUNT_W'(1); // [R17]
      slowCntQ   <= slowWrap ? '0 : slowCntQ + COUNT_W'(1); // [R17]
      fastPhaseQ <= fastPhaseQ ^ fastWrap;
      slowPhaseQ <= slowPhaseQ ^ slowWrap;
    end
  end

  // Event stretchers, shared by both LEDs since the length is global.
  wire [2:0] rawEvent = {collisionEvent, rxEvent, txEvent};
  wire [2:0] stEvent;

  genvar e;
  generate
    for (e = 0; e < 3; e++) begin : g_stretch
      lis_event_stretch #(
        .COUNT_W (COUNT_W),
        .LEN0    (STRETCH_SHORT_CYC),
        .LEN1    (STRETCH_MID_CYC),
        .LEN2    (STRETCH_LONG_CYC)
      ) u_stretch (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .eventIn   (rawEvent[e]),
        .lenSel    (lenSel),
        .stretched (stEvent[e])
      ); // [R16]
    end
  endgenerate

  // Single-event sources honour the global enable; combined modes never do.
  wire txShown  = stretchEn ? stEvent[0] : txEvent;        // [R3]
  wire rxShown  = stretchEn ? stEvent[1] : rxEvent;        // [R3]
  wire colShown = stretchEn ? stEvent[2] : collisionEvent; // [R3]
  wire actShown = txShown || rxShown;                      // [R5]
  wire stAct    = stEvent[0] || stEvent[1];                // [R13]

  // Per-LED source selection.
  logic [1:0] ledD;
  logic [1:0] ledQ;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_led
      always_comb begin
        unique case (selCode[c])
          SEL_SPEED:    ledD[c] = speedIs100;
          SEL_TX:       ledD[c] = txShown;                                // [R3]
          SEL_RX:       ledD[c] = rxShown;                                // [R3]
          SEL_COL:      ledD[c] = colShown;                               // [R3]
          SEL_LINK:     ledD[c] = linkUp;                                 // [R4]
          SEL_DUPLEX:   ledD[c] = fullDuplex;                             // [R4]
          SEL_ACT:      ledD[c] = actShown;                               // [R5]
          SEL_ON:       ledD[c] = 1'b1;                                   // [R6]
          SEL_OFF:      ledD[c] = 1'b0;                                   // [R6]
          SEL_FAST:     ledD[c] = fastPhaseQ;                             // [R7]
          SEL_SLOW:     ledD[c] = slowPhaseQ;                             // [R7]
          SEL_LINK_RX:  ledD[c] = stEvent[1] ? fastPhaseQ : linkUp;       // [R9] [R11] [R13]
          SEL_LINK_ACT: ledD[c] = stAct ? fastPhaseQ : linkUp;            // [R10] [R11] [R13]
          SEL_DUP_COL:  ledD[c] = stEvent[2] ? fastPhaseQ : fullDuplex;   // [R12] [R13] [R14]
          SEL_RSVD6,
          SEL_RSVD15:   ledD[c] = 1'b0;                                   // [R8]
        endcase
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ledQ <= 2'h0;
    end else begin
      ledQ <= ledD;
    end
  end

  assign firstLedOn  = ledQ[0];
  assign secondLedOn = ledQ[1];

  // Checks.
  a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    ackQ |=> !ackQ)
    else $error("ack held longer than one cycle");

  a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
    (writeFire && wb_sel_i[1]) |=> (cfgQ[15:8] == $past(wb_dat_i[15:8])))
    else $error("configuration write did not land");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (busReq && !ackQ && !cfgHit) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned data");

  a_force_on_off: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
    (selCode[0] == SEL_ON) ##1 (selCode[0] == SEL_OFF) |-> firstLedOn ##1 !firstLedOn)
    else $error("forced LED level wrong");

  a_link_shown: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    (selCode[1] == SEL_LINK) |=> (secondLedOn == $past(linkUp)))
    else $error("second LED does not follow link");

  a_duplex_shown: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    (selCode[0] == SEL_DUPLEX) |=> (firstLedOn == $past(fullDuplex)))
    else $error("first LED does not follow duplex");

  a_tx_stretched: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
    (selCode[0] == SEL_TX && stretchEn && txEvent) ##1
      (selCode[0] == SEL_TX && stretchEn)[*3] |=> firstLedOn)
    else $error("transmit event not stretched");

  a_tx_raw: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
    (selCode[0] == SEL_TX && !stretchEn) |=> (firstLedOn == $past(txEvent)))
    else $error("transmit shown stretched while disabled");

  a_combined_solid: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
    (selCode[1] == SEL_LINK_RX && !stEvent[1]) |=> (secondLedOn == $past(linkUp)))
    else $error("link and receive mode not solid");

  a_combined_blink: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
    (selCode[0] == SEL_LINK_ACT && !stretchEn && (txEvent || rxEvent))
      |=> (firstLedOn == $past(fastPhaseQ)))
    else $error("activity did not blink while stretch disabled");

  a_dupcol_blink: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
    (selCode[1] == SEL_DUP_COL && stEvent[2]) |=> (secondLedOn == $past(fastPhaseQ)))
    else $error("collision did not blink");

  a_slow_longer: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
    $changed(slowPhaseQ) |-> !$changed(fastPhaseQ) || (SLOW_HALF_CYC > FAST_HALF_CYC))
    else $error("slow blink not slower than fast");

endmodule // led_indicator_select

// >>> logic/lis_cfg.svh
// Constants for the indicator LED select block: offsets, fields, resets and timing.
`ifndef LIS_CFG_SVH
`define LIS_CFG_SVH

`define LIS_CFG_OFFSET        8'h14
`define LIS_ADDR_W            8
`define LIS_CFG_RESET         16'h0422
`define LIS_FIRST_SEL_HI      15
`define LIS_FIRST_SEL_LO      12
`define LIS_SECOND_SEL_HI     11
`define LIS_SECOND_SEL_LO     8
`define LIS_SPARE_SEL_HI      7
`define LIS_SPARE_SEL_LO      4
`define LIS_LEN_HI            3
`define LIS_LEN_LO            2
`define LIS_STRETCH_EN_BIT    1
`define LIS_CLK_HZ            10000000
`define LIS_STRETCH_SHORT_MS  30
`define LIS_STRETCH_MID_MS    60
`define LIS_STRETCH_LONG_MS   100
`define LIS_FAST_HALF_MS      50
`define LIS_SLOW_HALF_MS      250
`define LIS_MS_TO_CYC(ms)     ((ms) * (`LIS_CLK_HZ / 1000))

`endif

// >>> logic/lis_event_stretch.sv
// Stretches a short event into a pulse of selectable length.
module lis_event_stretch #(
  parameter int COUNT_W = 20,
  parameter int LEN0    = 300000,
  parameter int LEN1    = 600000,
  parameter int LEN2    = 1000000
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             eventIn,
  input  wire lis_pkg::lis_len_t lenSel,
  output wire logic             stretched
);
  import lis_pkg::*;

  logic [COUNT_W-1:0] cntQ;
  logic [COUNT_W-1:0] cntD;
  wire  [COUNT_W-1:0] loadVal;

  // The reserved length code falls back to the shortest stretch.
  assign loadVal = (lenSel == 2'h1) ? COUNT_W'(LEN1 - 1) :
                   (lenSel == 2'h2) ? COUNT_W'(LEN2 - 1) : COUNT_W'(LEN0 - 1);
  assign cntD = eventIn ? loadVal : ((cntQ != '0) ? cntQ - COUNT_W'(1) : cntQ);
  assign stretched = eventIn || (cntQ != '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cntQ <= '0;
    end else begin
      cntQ <= cntD;
    end
  end

endmodule // lis_event_stretch

// >>> logic/lis_pkg.sv
// Types shared by the indicator LED select block.
package lis_pkg;

  typedef enum logic [3:0] {
    SEL_SPEED, SEL_TX, SEL_RX, SEL_COL, SEL_LINK, SEL_DUPLEX, SEL_RSVD6, SEL_ACT,
    SEL_ON, SEL_OFF, SEL_FAST, SEL_SLOW, SEL_LINK_RX, SEL_LINK_ACT, SEL_DUP_COL, SEL_RSVD15
  } lis_sel_e;

  typedef logic [1:0] lis_len_t;

endpackage

// >>> verif/led_indicator_select_tb.sv
// Self-checking bench for the indicator LED select block.
`include "lis_cfg.svh"
module led_indicator_select_tb;
  import lis_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LEN0 = 8;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] datW = 32'h0;
  logic [31:0] datO;
  logic [31:0] datR;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
  logic        spd = 1'b0, tx = 1'b0, rx = 1'b0, col = 1'b0, link = 1'b0, dup = 1'b0;
  logic        first_indicator_select, second_indicator_select;
  int          badCount = 0, checksDone = 0, run, rises, r0;
  logic [3:0]  codes [5] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9};
  logic [1:0]  expA  [5] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b00};

  initial forever #50 core_clk = ~core_clk;

  led_indicator_select #(.STRETCH_SHORT_CYC(8), .STRETCH_MID_CYC(12), .STRETCH_LONG_CYC(16),
    .FAST_HALF_CYC(4), .SLOW_HALF_CYC(10)) u_led_indicator_select (
    .core_clk(core_clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(datW), .wb_dat_o(datO),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .speedIs100(spd), .txEvent(tx), .rxEvent(rx), .collisionEvent(col), .linkUp(link),
    .fullDuplex(dup), .firstLedOn(first_indicator_select), .secondLedOn(second_indicator_select));

  lis_led_board u_lis_led_board (.core_clk(core_clk), .ledOn(first_indicator_select), .runLen(run),
    .riseCnt(rises));

  task automatic summarize();
    if (badCount == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string m);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkLed(input logic e1, input logic e2);
    // Let the LED register take the latest status before looking at it.
    @(posedge core_clk);
    @(negedge core_clk);
    chkVal({31'h0, first_indicator_select}, {31'h0, e1}, "first LED");
    chkVal({31'h0, second_indicator_select}, {31'h0, e2}, "second LED");
  endtask

  // Classic single cycle: hold everything until ack is seen, then release.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {cyc, stb, we, adr, datW, sel} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      badCount++;
      $display("[FAIL] %0t bus timeout", $time);
      summarize();
    end
    datR = datO;
    @(posedge core_clk);
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic setCfg(input logic [3:0] c1, input logic [3:0] c2, input logic [1:0] len,
                        input logic en);
    xfer(1'b1, `LIS_CFG_OFFSET, {16'h0, c1, c2, 4'h2, len, en, 1'b0});
  endtask

  task automatic pulse(input int k);
    @(posedge core_clk);
    {tx, rx, col} <= 3'b001 << (2 - k);
    @(posedge core_clk);
    {tx, rx, col} <= 3'b000;
  endtask

  task automatic blinkChk(input logic [3:0] c, input int k);
    setCfg(c, 4'h9, 2'b00, 1'b0);
    repeat (3) @(posedge core_clk);
    r0 = rises;
    pulse(k);
    repeat (20) @(posedge core_clk);
    chkVal({31'h0, rises > r0}, 32'h1, "combined blink");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(1'b0, `LIS_CFG_OFFSET, 32'h0);
    chkVal(datR, 32'h0422, "reset value");
    xfer(1'b1, 8'h10, 32'hffff);
    xfer(1'b0, 8'h10, 32'h0);
    chkVal(datR, 32'h0, "unmapped read");
    {spd, link, dup} <= 3'b110;
    chkLed(1'b1, 1'b1);
    // Codes 0110 and 1111 are never programmed.
    for (int s = 0; s < 2; s++) begin
      {spd, link, dup} <= (s == 0) ? 3'b110 : 3'b001;
      for (int i = 0; i < 5; i++) begin
        setCfg(codes[i], 4'h5, 2'b00, 1'b1);
        repeat (2) @(posedge core_clk);
        chkLed((i > 2) ? expA[i][1] : (expA[i][1] ^ s[0]), s[0]);
      end
    end
    {spd, link, dup} <= 3'b000;
    for (int i = 0; i < 5; i++) begin
      setCfg((i == 3) ? 4'h7 : 4'(i % 4 + 1), 4'h9, 2'(i % 3), 1'b1);
      pulse((i == 4) ? 0 : i % 3);
      repeat (24) @(posedge core_clk);
      chkVal(run, LEN0 + 4 * (i % 3), "stretch length");
    end
    setCfg(4'h1, 4'h9, 2'b00, 1'b0);
    pulse(0);
    repeat (5) @(posedge core_clk);
    chkVal(run, 1, "stretch disabled");
    setCfg(4'ha, 4'h9, 2'b00, 1'b1);
    repeat (30) @(posedge core_clk);
    chkVal(run, 4, "fast blink");
    setCfg(4'hb, 4'h9, 2'b00, 1'b1);
    repeat (45) @(posedge core_clk);
    chkVal(run, 10, "slow blink");
    blinkChk(4'hd, 1);
    link <= 1'b1;
    blinkChk(4'hc, 1);
    chkLed(1'b1, 1'b0);
    {link, dup} <= 2'b01;
    blinkChk(4'he, 2);
    chkLed(1'b1, 1'b0);
    summarize();
  end
endmodule // led_indicator_select_tb

// >>> verif/lis_led_board.sv
// Board-side LED model that measures lit run lengths and turn-on counts.
module lis_led_board (
  input  wire logic core_clk,
  input  wire logic ledOn,
  output int        runLen,
  output int        riseCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cur = 0;
  logic prevOn = 1'b0;
  initial begin
    runLen = 0;
    riseCnt = 0;
  end
  // The LED is a plain load, so only its lit time and turn-on count matter.
  always @(posedge core_clk) begin
    if (ledOn === 1'b1) begin
      cur <= cur + 1;
    end else begin
      if (cur != 0) begin
        runLen <= cur;
      end
      cur <= 0;
    end
    if (ledOn === 1'b1 && prevOn !== 1'b1) begin
      riseCnt <= riseCnt + 1;
    end
    prevOn <= ledOn;
  end
endmodule // lis_led_board
